// ==== src/sfc_core.sv ====
// serial float coprocessor: link, interpreter, arithmetic, port, bus
`timescale 1ns/10ps

//
// Overview of operation
// RQ1 - grounded strap: pull select pin while busy
// RQ2 - host disables by pulling select pin low
// RQ3 - pulled-up strap: drive strap high while busy
// RQ4 - release data line until result ready
// RQ5 - magnitude clears negative sign; negate flips sign
// RQ6 - sum and difference into accumulator
// RQ7 - product and quotient into accumulator
// RQ8 - link check answers base plus version
// RQ9 - digit zero returns sign character
// RQ10 - small argument returns integer digit
// RQ11 - large argument returns fraction digit
// RQ12 - digit extraction keeps registers, 24-bit limit
// RQ13 - direction byte sets outputs; inputs after reset
// RQ14 - integer mantissa converts to normalised real
// RQ15 - convert between native and standard layout
// RQ16 - real converts to 24-bit integer
// RQ17 - load takes four bytes, exponent first
// RQ18 - options byte: saturation and rounding flags
// RQ19 - save, recall, exchange and copy registers
// RQ20 - read sends four accumulator bytes
// RQ21 - port read returns pins, outputs as driven
// RQ22 - port write changes only output pins
// RQ23 - msb first, sampled on rising link clock
// RQ24 - data rise while clock high resets link
// RQ25 - status byte holds four error flags
// RQ26 - native sign sits atop second byte
// RQ27 - opcode, then arguments, then results
module sfc_core #(
  parameter int PORT_W = 8,
  parameter logic [7:0] FW_VERSION = 8'h01 // arbitrary value
) (
  // system
  input logic clk_i,
  input logic rst_i,
  // wishbone slave
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [3:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial link
  input logic link_clk_i,
  input logic serial_in_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  // select-and-ready pin
  input logic sel_ready_i,
  output logic sel_ready_o,
  output logic sel_ready_oe_o,
  // busy strap pin
  input logic busy_strap_i,
  output logic busy_strap_o,
  output logic busy_strap_oe_o,
  // general purpose port
  input logic [PORT_W-1:0] port_i,
  output logic [PORT_W-1:0] port_o,
  output logic [PORT_W-1:0] port_oe_o
);

  ////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (PORT_W != 8) begin : g_bad_port
    $error("port must be one byte wide");
  end
  if (sfc_pkg::DIGIT_MAX_CYC > sfc_pkg::QUOT_CYC) begin : g_bad_time
    $error("digit extraction exceeds quotient time");
  end

  ////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    sfc_pkg::sfc_state_t st;
    logic [1:0] sck_s;
    logic [1:0] sin_s;
    logic [1:0] en_s;
    logic [1:0] bs_s;
    logic [7:0] prt_a;
    logic [7:0] prt_b;
    logic sck_p;
    logic sin_p;
    logic [1:0] drv_h;
    logic [1:0] sc;
    logic strap_done;
    logic strap_low;
    logic rst_pend;
    logic [7:0] sh;
    logic [2:0] bits;
    logic [2:0] nbytes;
    logic [7:0] op;
    logic [31:0] argw;
    logic [31:0] acc;
    logic [31:0] opd;
    logic [31:0] scratch_a;
    logic [31:0] scratch_b;
    logic [7:0] opts;
    logic [7:0] dirs;
    logic [7:0] pout;
    logic [7:0] stat;
    logic [31:0] res;
    logic [6:0] cnt;
    logic [23:0] wk;
    logic [3:0] dg;
    logic ctl_hold;
    logic ack;
    logic [31:0] wdat;
  } sfc_st_t;

  sfc_st_t q;
  sfc_st_t d;

  logic sck;
  logic din;
  logic rise;
  logic fall;
  logic busy;
  logic sel_drv;
  logic dis;
  logic [7:0] byte_in;
  logic [7:0] port_rd;

  ////////////////////////////////////////////////////////////////////
  // arithmetic helpers

  // round, saturate, flag; returns {underflow, overflow, value}
  function automatic logic [33:0] pack(input logic s,
      input logic signed [10:0] e, input logic [24:0] m,
      input logic sat, input logic rnd);
    logic [24:0] r;
    logic signed [10:0] ee;
    r = {1'b0, m[24:1]} + {24'h0, rnd & m[0]};
    ee = e;
    if (r[24]) begin
      r = r >> 1;
      ee = ee + 11'sd1;
    end
    if (ee > 11'(sfc_pkg::EXP_TOP + 1)) begin
      pack = {2'b01, sat ? {8'hff, s, 23'h7fffff} : {ee[7:0], s, r[22:0]}};
    end else if (ee < 11'sd1) begin
      pack = {2'b10, sat ? {8'h01, s, 23'h0} : 32'h0};
    end else begin
      pack = {2'b00, ee[7:0], s, r[22:0]};
    end
  endfunction : pack

  // add or subtract in native layout
  function automatic logic [33:0] fadd(input logic [31:0] a,
      input logic [31:0] b, input logic sub, input logic sat,
      input logic rnd);
    logic [31:0] x;
    logic [31:0] y;
    logic [25:0] mx;
    logic [25:0] my;
    logic [7:0] dd;
    logic signed [10:0] e;
    logic sy;
    x = a;
    y = {b[31:24], b[23] ^ sub, b[22:0]};
    // larger magnitude first keeps the difference positive
    if ({y[31:24], y[22:0]} > {x[31:24], x[22:0]}) begin
      x = y;
      y = a;
    end
    sy = (y == a) ? a[23] : y[23];
    mx = {1'b0, |x[31:24], x[22:0], 1'b0};
    my = {1'b0, |y[31:24], y[22:0], 1'b0};
    dd = x[31:24] - y[31:24];
    my = my >> dd;
    mx = (x[23] == sy) ? mx + my : mx - my;
    e = 11'(x[31:24]);
    if (mx[25]) begin
      mx = mx >> 1;
      e = e + 11'sd1;
    end
    for (int i = 0; i < 25; i++) begin
      if (!mx[24] && mx != 26'h0) begin
        mx = mx << 1;
        e = e - 11'sd1;
      end
    end
    if (mx == 26'h0) begin
      fadd = 34'h0;
    end else begin
      fadd = pack(x[23], e, mx[24:0], sat, rnd);
    end
  endfunction : fadd

  // product; zero operand gives zero
  function automatic logic [33:0] fmul(input logic [31:0] a,
      input logic [31:0] b, input logic sat, input logic rnd);
    logic [47:0] p;
    logic signed [10:0] e;
    p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
    e = 11'(a[31:24]) + 11'(b[31:24]) - 11'(sfc_pkg::EXP_BIAS);
    if (a[31:24] == 8'h0 || b[31:24] == 8'h0) begin
      fmul = 34'h0;
    end else if (p[47]) begin
      fmul = pack(a[23] ^ b[23], e + 11'sd1, p[47:23], sat, rnd);
    end else begin
      fmul = pack(a[23] ^ b[23], e, p[46:22], sat, rnd);
    end
  endfunction : fmul

  // quotient; caller handles a zero divisor
  function automatic logic [33:0] fdiv(input logic [31:0] a,
      input logic [31:0] b, input logic sat, input logic rnd);
    logic [49:0] n;
    logic [49:0] qq;
    logic signed [10:0] e;
    n = {1'b1, a[22:0], 26'h0};
    qq = n / {26'h0, 1'b1, b[22:0]};
    e = 11'(a[31:24]) - 11'(b[31:24]) + 11'(sfc_pkg::EXP_BIAS);
    if (a[31:24] == 8'h0) begin
      fdiv = 34'h0;
    end else if (qq[26]) begin
      fdiv = pack(a[23] ^ b[23], e, qq[26:2], sat, rnd);
    end else begin
      fdiv = pack(a[23] ^ b[23], e - 11'sd1, qq[25:1], sat, rnd);
    end
  endfunction : fdiv

  // magnitude as fixed point, 24 integer and 24 fraction bits
  function automatic logic [47:0] fixed(input logic [31:0] a);
    logic [47:0] m;
    m = {1'b1, a[22:0], 24'h0};
    if (a[31:24] == 8'h0) begin
      fixed = 48'h0;
    end else if (a[31:24] > 8'(sfc_pkg::INT_EXP)) begin
      fixed = m << (a[31:24] - 8'(sfc_pkg::INT_EXP));
    end else begin
      fixed = m >> (8'(sfc_pkg::INT_EXP) - a[31:24]);
    end
  endfunction : fixed

  // bytes that follow each opcode
  function automatic logic [2:0] arg_bytes(input logic [7:0] op);
    case (op)
      sfc_pkg::OP_LOAD_ACC, sfc_pkg::OP_LOAD_OPD: arg_bytes = 3'd4;
      sfc_pkg::OP_DIGIT, sfc_pkg::OP_DIR, sfc_pkg::OP_OPTIONS,
      sfc_pkg::OP_PORT_WRITE: arg_bytes = 3'd1;
      default: arg_bytes = 3'd0;
    endcase
  endfunction : arg_bytes

  ////////////////////////////////////////////////////////////////////
  // pin decode
  assign sck = q.sck_s[1];
  assign din = q.sin_s[1];
  assign rise = sck & ~q.sck_p;
  assign fall = ~sck & q.sck_p;
  // RQ23 - msb first shift
  assign byte_in = {q.sh[6:0], din};
  assign busy = (q.st == sfc_pkg::ST_EXEC);
  // RQ1 - pull select pin low while busy
  assign sel_drv = q.strap_done & q.strap_low & busy;
  // RQ2 - host low on select disables, own pull masked
  assign dis = (~q.en_s[1] & ~sel_drv & ~|q.drv_h) | q.ctl_hold;
  // RQ21 - outputs read back their driven value
  assign port_rd = (q.dirs & q.pout) | (~q.dirs & q.prt_b);

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [33:0] r;
    logic [47:0] fx;
    logic [27:0] t;
    logic [23:0] rm;
    logic [23:0] iv;
    logic [7:0] ch;
    logic [7:0] a;
    logic [2:0] n;
    logic [31:0] rv;
    r = 34'h0;
    fx = fixed(q.acc);
    t = 28'h0;
    rm = 24'h0;
    iv = 24'h0;
    ch = sfc_pkg::CH_SPACE;
    a = q.argw[7:0];
    n = 3'd0;
    rv = 32'h0;
    d = q;

    // two-stage synchronisers and edge history
    d.sck_s = {q.sck_s[0], link_clk_i};
    d.sin_s = {q.sin_s[0], serial_in_pin_i};
    d.en_s = {q.en_s[0], sel_ready_i};
    d.bs_s = {q.bs_s[0], busy_strap_i};
    d.prt_a = port_i;
    d.prt_b = q.prt_a;
    d.sck_p = sck;
    d.sin_p = din;
    d.drv_h = {q.drv_h[0], sel_drv};

    // strap caught a few cycles after reset release
    if (!q.strap_done) begin
      d.sc = q.sc + 2'd1;
      if (q.sc == 2'(sfc_pkg::STRAP_WAIT)) begin
        d.strap_done = 1'b1;
        d.strap_low = ~q.bs_s[1];
      end
    end

    unique case (q.st)
      sfc_pkg::ST_IDLE, sfc_pkg::ST_ARG: begin
        // RQ23 - sample data on rising link clock
        if (rise) begin
          d.sh = byte_in;
          d.bits = q.bits + 3'd1;
          if (q.bits == 3'd7 && q.st == sfc_pkg::ST_IDLE) begin
            // RQ27 - opcode first, then its arguments
            d.op = byte_in;
            d.nbytes = arg_bytes(byte_in);
            d.st = (arg_bytes(byte_in) == 3'd0) ? sfc_pkg::ST_EXEC
                                                 : sfc_pkg::ST_ARG;
          end else if (q.bits == 3'd7) begin
            // RQ17 - argument bytes collect exponent first
            d.argw = {q.argw[23:0], byte_in};
            d.nbytes = q.nbytes - 3'd1;
            if (q.nbytes == 3'd1) begin
              d.st = sfc_pkg::ST_EXEC;
              d.cnt = 7'h0;
              // RQ10 - integer digit: divide by ten repeatedly
              if (byte_in != 8'h0 && byte_in < sfc_pkg::DIG_INT_LIM) begin
                d.wk = fx[47:24];
                d.cnt = byte_in[6:0] - 7'd1;
              end
              // RQ11 - fraction digit: multiply by ten repeatedly
              if (byte_in > sfc_pkg::DIG_FRAC) begin
                d.wk = fx[23:0];
                d.cnt = byte_in[6:0];
              end
            end
          end
        end
      end
      sfc_pkg::ST_EXEC: begin
        // RQ12 - digit work writes only wk, dg and cnt
        if (q.op == sfc_pkg::OP_DIGIT && q.cnt != 7'h0) begin
          d.cnt = q.cnt - 7'd1;
          if (q.argw[7]) begin
            t = {4'h0, q.wk} * 28'd10;
            d.dg = t[27:24];
            d.wk = t[23:0];
          end else begin
            d.wk = q.wk / 24'd10;
          end
        end else begin
          d.st = sfc_pkg::ST_IDLE;
          case (q.op)
            // RQ6 - sum and difference, operand kept
            sfc_pkg::OP_SUM, sfc_pkg::OP_DIFF: begin
              r = fadd(q.acc, q.opd, q.op == sfc_pkg::OP_DIFF,
                       q.opts[sfc_pkg::OPT_SAT], q.opts[sfc_pkg::OPT_RND]);
            end
            // RQ7 - product and quotient, operand kept
            sfc_pkg::OP_PRODUCT: begin
              r = fmul(q.acc, q.opd, q.opts[sfc_pkg::OPT_SAT],
                       q.opts[sfc_pkg::OPT_RND]);
            end
            sfc_pkg::OP_QUOT: begin
              r = fdiv(q.acc, q.opd, q.opts[sfc_pkg::OPT_SAT],
                       q.opts[sfc_pkg::OPT_RND]);
            end
            // RQ14 - two's complement integer to real
            sfc_pkg::OP_TO_REAL: begin
              rm = q.acc[23] ? 24'h0 - q.acc[23:0] : q.acc[23:0];
              t = {3'h0, rm, 1'b0};
              for (int i = 0; i < 24; i++) begin
                if (!t[24] && t != 28'h0) begin
                  t = t << 1;
                end
              end
              r = (rm == 24'h0) ? 34'h0 : pack(q.acc[23],
                  11'(sfc_pkg::INT_EXP) - 11'(24 - $clog2(rm + 24'h1)),
                  t[24:0], 1'b0, 1'b0);
            end
            default: begin
            end
          endcase
          case (q.op)
            sfc_pkg::OP_SUM, sfc_pkg::OP_DIFF, sfc_pkg::OP_PRODUCT,
            sfc_pkg::OP_QUOT, sfc_pkg::OP_TO_REAL: begin
              // RQ25 - error flags in status byte
              d.stat = 8'h0;
              d.stat[sfc_pkg::ST_FOVF] = r[32];
              d.stat[sfc_pkg::ST_FUNF] = r[33];
              if (q.op == sfc_pkg::OP_QUOT && q.opd[31:24] == 8'h0) begin
                d.stat = 8'h0;
                d.stat[sfc_pkg::ST_DIVZ] = 1'b1;
              end else begin
                d.acc = r[31:0];
              end
              n = 3'd1;
              rv = {d.stat, 24'h0};
            end
            // RQ16 - whole number in the mantissa field
            sfc_pkg::OP_TO_WHOLE: begin
              iv = q.acc[23] ? 24'h0 - fx[47:24] : fx[47:24];
              d.acc = {8'h0, iv};
              d.stat = 8'h0;
              d.stat[sfc_pkg::ST_IOVF] = fx[47] |
                  (q.acc[31:24] > 8'(sfc_pkg::INT_EXP));
              n = 3'd1;
              rv = {d.stat, 24'h0};
            end
            // RQ15 - layout conversions
            // RQ26 - sign moves between bit 23 and bit 31
            sfc_pkg::OP_TO_STD: begin
              d.acc = {q.acc[23], q.acc[31:24], q.acc[22:0]};
            end
            sfc_pkg::OP_TO_NATIVE: begin
              d.acc = {q.acc[30:23], q.acc[31], q.acc[22:0]};
            end
            // RQ5 - magnitude and negate on the sign bit
            sfc_pkg::OP_MAGNITUDE: d.acc[23] = 1'b0;
            sfc_pkg::OP_NEGATE: d.acc[23] = ~q.acc[23];
            // RQ19 - register moves
            sfc_pkg::OP_EXCHANGE: begin
              d.acc = q.opd;
              d.opd = q.acc;
            end
            sfc_pkg::OP_ACC_TO_OPD: d.opd = q.acc;
            sfc_pkg::OP_OPD_TO_ACC: d.acc = q.opd;
            sfc_pkg::OP_SAVE_A: d.scratch_a = q.acc;
            sfc_pkg::OP_SAVE_B: d.scratch_b = q.acc;
            sfc_pkg::OP_RECALL_A: d.acc = q.scratch_a;
            sfc_pkg::OP_RECALL_B: d.acc = q.scratch_b;
            // RQ17 - loads store the four bytes unchanged
            sfc_pkg::OP_LOAD_ACC: d.acc = q.argw;
            sfc_pkg::OP_LOAD_OPD: d.opd = q.argw;
            // RQ18 - option flags
            sfc_pkg::OP_OPTIONS: d.opts = a & sfc_pkg::OPT_MASK;
            // RQ13 - set bits make pins outputs
            sfc_pkg::OP_DIR: d.dirs = a;
            // RQ22 - latch drives only where enabled
            sfc_pkg::OP_PORT_WRITE: d.pout = a;
            // RQ21 - port state answered at once
            sfc_pkg::OP_PORT_READ: begin
              n = 3'd1;
              rv = {port_rd, 24'h0};
            end
            // RQ8 - fixed base plus version
            sfc_pkg::OP_LINK_CHECK: begin
              n = 3'd1;
              rv = {sfc_pkg::LINK_BASE + FW_VERSION, 24'h0};
            end
            // RQ20 - four bytes, exponent first
            sfc_pkg::OP_READ_ACC: begin
              n = 3'd4;
              rv = q.acc;
            end
            sfc_pkg::OP_DIGIT: begin
              rm = q.wk % 24'd10;
              // RQ9 - sign character for argument zero
              if (a == 8'h0) begin
                ch = (q.acc[31:24] == 8'h0) ? sfc_pkg::CH_SPACE
                   : q.acc[23] ? sfc_pkg::CH_MINUS : sfc_pkg::CH_PLUS;
              end else if (a < sfc_pkg::DIG_INT_LIM) begin
                ch = sfc_pkg::CH_ZERO + {4'h0, rm[3:0]};
              end else if (a > sfc_pkg::DIG_FRAC) begin
                ch = sfc_pkg::CH_ZERO + {4'h0, q.dg};
              end
              n = 3'd1;
              rv = {ch, 24'h0};
            end
            default: begin
            end
          endcase
          // RQ27 - results follow execution
          if (n != 3'd0) begin
            d.st = sfc_pkg::ST_SEND;
            d.res = rv;
            d.nbytes = n;
            d.bits = 3'd0;
          end
        end
      end
      sfc_pkg::ST_SEND: begin
        // advance on rise: host sampled before it, last fall is not ours
        if (rise) begin
          d.res = q.res << 1;
          d.bits = q.bits + 3'd1;
          if (q.bits == 3'd7) begin
            d.nbytes = q.nbytes - 3'd1;
            if (q.nbytes == 3'd1) begin
              d.st = sfc_pkg::ST_IDLE;
            end
          end
        end
      end
    endcase

    // RQ24 - data rise with clock high, acted on at fall
    if (fall && q.rst_pend) begin
      d.st = sfc_pkg::ST_IDLE;
      d.bits = 3'd0;
      d.rst_pend = 1'b0;
    end
    if (sck && q.sck_p && din && !q.sin_p && q.st != sfc_pkg::ST_SEND) begin
      d.rst_pend = 1'b1;
    end
    // RQ2 - disabled device forgets any transfer
    if (dis) begin
      d.st = sfc_pkg::ST_IDLE;
      d.bits = 3'd0;
      d.rst_pend = 1'b0;
    end

    // wishbone: answer one cycle after request, write at ack edge
    d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      case (wb_adr_i[3:2])
        sfc_pkg::REG_STATUS: d.wdat = {7'h0, busy, q.dirs, q.opts, q.stat};
        sfc_pkg::REG_ACC: d.wdat = q.acc;
        sfc_pkg::REG_CTRL: d.wdat = {31'h0, q.ctl_hold};
        default: d.wdat = 32'h0;
      endcase
    end
    if (wb_cyc_i && wb_stb_i && wb_we_i && q.ack && wb_sel_i[0] &&
        wb_adr_i[3:2] == sfc_pkg::REG_CTRL) begin
      d.ctl_hold = wb_dat_i[sfc_pkg::CTRL_HOLD];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register; reset clears port directions to inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_dat_o = q.wdat;
  assign wb_ack_o = q.ack;
  // RQ4 - line released (high) until the answer shifts
  assign serial_out_pin_o = 1'b0;
  assign serial_out_pin_oe_o = (q.st == sfc_pkg::ST_SEND) & ~q.res[31];
  assign sel_ready_o = 1'b0;
  assign sel_ready_oe_o = sel_drv;
  // RQ3 - strap pulled up: drive it as a busy flag
  assign busy_strap_o = busy;
  assign busy_strap_oe_o = q.strap_done & ~q.strap_low;
  assign port_o = q.pout;
  assign port_oe_o = q.dirs;

endmodule : sfc_core

// ==== src/sfc_pkg.sv ====
// constants and types of the serial float coprocessor
package sfc_pkg;
  // clock rate and worst-case operation times
  localparam int CLK_MHZ = 20;
  localparam int T_SUM_US = 110;
  localparam int T_PROD_US = 240;
  localparam int T_QUOT_US = 380;
  localparam int SUM_CYC = T_SUM_US * CLK_MHZ;
  localparam int PROD_CYC = T_PROD_US * CLK_MHZ;
  localparam int QUOT_CYC = T_QUOT_US * CLK_MHZ;
  localparam int DIGIT_MAX_CYC = 130;
  localparam int STRAP_WAIT = 3;

  // command opcodes
  localparam logic [7:0] OP_LOAD_ACC = 8'h01;
  localparam logic [7:0] OP_LOAD_OPD = 8'h02;
  localparam logic [7:0] OP_READ_ACC = 8'h03;
  localparam logic [7:0] OP_SAVE_A = 8'h04;
  localparam logic [7:0] OP_RECALL_A = 8'h05;
  localparam logic [7:0] OP_SUM = 8'h07;
  localparam logic [7:0] OP_DIFF = 8'h08;
  localparam logic [7:0] OP_PRODUCT = 8'h09;
  localparam logic [7:0] OP_QUOT = 8'h0a;
  localparam logic [7:0] OP_TO_REAL = 8'h0b;
  localparam logic [7:0] OP_TO_WHOLE = 8'h0c;
  localparam logic [7:0] OP_TO_STD = 8'h0d;
  localparam logic [7:0] OP_TO_NATIVE = 8'h0e;
  localparam logic [7:0] OP_MAGNITUDE = 8'h0f;
  localparam logic [7:0] OP_NEGATE = 8'h10;
  localparam logic [7:0] OP_EXCHANGE = 8'h11;
  localparam logic [7:0] OP_LINK_CHECK = 8'h12;
  localparam logic [7:0] OP_DIGIT = 8'h13;
  localparam logic [7:0] OP_DIR = 8'h14;
  localparam logic [7:0] OP_PORT_READ = 8'h15;
  localparam logic [7:0] OP_PORT_WRITE = 8'h16;
  localparam logic [7:0] OP_ACC_TO_OPD = 8'h17;
  localparam logic [7:0] OP_OPD_TO_ACC = 8'h18;
  localparam logic [7:0] OP_OPTIONS = 8'h19;
  localparam logic [7:0] OP_SAVE_B = 8'h92;
  localparam logic [7:0] OP_RECALL_B = 8'h93;

  // answer characters and option / status fields
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] LINK_BASE = 8'h20;
  localparam logic [7:0] DIG_INT_LIM = 8'h7f;
  localparam logic [7:0] DIG_FRAC = 8'h80;
  localparam logic [7:0] OPT_MASK = 8'hc0;
  localparam int OPT_SAT = 7;
  localparam int OPT_RND = 6;
  localparam int ST_IOVF = 0;
  localparam int ST_FOVF = 1;
  localparam int ST_FUNF = 2;
  localparam int ST_DIVZ = 3;
  localparam int EXP_BIAS = 127;
  localparam int EXP_TOP = 254;
  localparam int INT_EXP = 150;

  // register word indices and control field
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_ACC = 2'h1;
  localparam logic [1:0] REG_CTRL = 2'h2;
  localparam int CTRL_HOLD = 0;

  // link sequencer states, gray along idle-arg-exec-send
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARG = 2'b01,
    ST_EXEC = 2'b11,
    ST_SEND = 2'b10
  } sfc_state_t;
endpackage : sfc_pkg

// ==== test/sfc_core_props.sv ====
// port assertions of the serial float coprocessor
`timescale 1ns/10ps
module sfc_core_props (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_pin_oe_o,
  input wire logic sel_ready_o,
  input wire logic sel_ready_oe_o,
  input wire logic busy_strap_o,
  input wire logic busy_strap_oe_o,
  input wire logic [7:0] port_oe_o
);
  // one clock domain, reset cancels every check
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack late");
  chk_ack_cause: assert property ($rose(wb_ack_o) |->
    $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  chk_pins_sink: assert property (!serial_out_pin_o && !sel_ready_o)
    else $error("open-collector pin driven high");
  chk_dirs_reset: assert property ($fell(rst_i) |-> port_oe_o == 8'h00)
    else $error("port not all inputs after reset");
  chk_line_quiet: assert property ($fell(rst_i) |->
    !serial_out_pin_oe_o [*8]) else $error("line pulled after reset");
  chk_mode_excl: assert property (busy_strap_oe_o |-> !sel_ready_oe_o)
    else $error("select pin pulled in strap mode");
  chk_sel_busy: assert property (busy_strap_o && !busy_strap_oe_o
    |-> sel_ready_oe_o) else $error("select pin not pulled");
  chk_busy_short: assert property (busy_strap_o |->
    ##[1:130] !busy_strap_o) else $error("busy too long");
endmodule : sfc_core_props

bind sfc_core sfc_core_props u_props (.*);

// ==== test/sfc_host_model.sv ====
// host model: drives link clock and data, reads the shared line
`timescale 1ns/10ps
module sfc_host_model (
  // shared line and host drives
  input wire logic line_i,
  output logic clk_o,
  output logic dat_o
);
  // clock stands low and data is released between frames
  initial begin
    clk_o = 1'b0;
    dat_o = 1'b1;
  end
  task automatic tx(input logic [7:0] v);
    #10;
    for (int i = 7; i >= 0; i--) begin
      dat_o = v[i];
      #200 clk_o = 1'b1;
      #200 clk_o = 1'b0;
    end
    #100 dat_o = 1'b1;
    #40;
  endtask : tx
  // sample while low, then pulse the clock
  task automatic rx(output logic [7:0] v);
    #10;
    for (int i = 7; i >= 0; i--) begin
      #200 v[i] = line_i;
      clk_o = 1'b1;
      #200 clk_o = 1'b0;
    end
    #40;
  endtask : rx
  // no clocking until the line goes low
  task automatic wait_low();
    for (int n = 0; n < 400 && line_i !== 1'b0; n++) #50;
  endtask : wait_low
  // data rises while the clock is high
  task automatic link_reset();
    #10 dat_o = 1'b0;
    #200 clk_o = 1'b1;
    #200 dat_o = 1'b1;
    #200 clk_o = 1'b0;
    #390;
  endtask : link_reset
endmodule : sfc_host_model

// ==== test/testbench.sv ====
// self-checking bench of the serial float coprocessor
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, strap_up = 1'b1, hdat, wb_ack_o, link_clk_i;
  logic serial_out_pin_o, serial_out_pin_oe_o, sel_ready_o, sel_ready_oe_o;
  logic busy_strap_o, busy_strap_oe_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, w;
  logic [7:0] port_i = 8'h5a, port_o, port_oe_o, b;
  logic [7:0] da [4] = '{8'h00, 8'h01, 8'h02, 8'h81};
  logic [7:0] de [4] = '{8'h2b, 8'h33, 8'h31, 8'h30};
  int err_total = 0, n_compared = 0;
  wire serial_in_pin_i = hdat & ~serial_out_pin_oe_o;
  wire sel_ready_i = ~sel_ready_oe_o;
  wire busy_strap_i = busy_strap_oe_o ? busy_strap_o : strap_up;
  // clock and instances; the version value is arbitrary
  always #25 clk_i = ~clk_i;
  sfc_core #(.FW_VERSION(8'h01)) u_sfc_core (.*);
  sfc_host_model u_host (.line_i(serial_in_pin_i), .clk_o(link_clk_i),
    .dat_o(hdat));
  // compare, bus cycle and link helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [3:0] a,
      input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
    w = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n == 50) err_total++;
  endtask : wb
  task automatic rd_acc(input logic [31:0] e);
    u_host.tx(sfc_pkg::OP_READ_ACC);
    for (int i = 3; i >= 0; i--) u_host.rx(w[8*i+:8]);
    chk(w, e);
  endtask : rd_acc
  task automatic ask(input logic [7:0] v, input logic [7:0] e);
    u_host.tx(v);
    u_host.wait_low();
    u_host.rx(b);
    chk(b, e);
  endtask : ask
  task automatic load(input logic [7:0] op, input logic [31:0] v,
      input int n);
    u_host.tx(op);
    for (int i = n - 1; i >= 0; i--) u_host.tx(v[8*i+:8]);
  endtask : load
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // watchdog well beyond the expected run
  initial begin
    #2000000;
    err_total++;
    close_out();
  end
  // test sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    wb(1'b0, 4'h0, 32'h0);
    chk(w, 32'h0);
    wb(1'b0, 4'hc, 32'h0);
    chk(w, 32'h0);
    wb(1'b1, 4'h8, 32'h1);
    wb(1'b0, 4'h8, 32'h0);
    chk(w, 32'h1);
    wb(1'b1, 4'h8, 32'h0);
    $display("bus test done");
    u_host.tx(sfc_pkg::OP_LINK_CHECK);
    u_host.rx(b);
    chk(b, sfc_pkg::LINK_BASE + 8'h01);
    load(sfc_pkg::OP_DIR, 32'h83, 1);
    load(sfc_pkg::OP_PORT_WRITE, 32'hff, 1);
    u_host.tx(sfc_pkg::OP_PORT_READ);
    u_host.rx(b);
    chk(b, 8'hdb);
    chk(port_o & port_oe_o, 8'h83);
    load(sfc_pkg::OP_OPTIONS, 32'hc0, 1);
    repeat (8) @(posedge clk_i);
    wb(1'b0, 4'h0, 32'h0);
    chk(w, 32'h0083c000);
    $display("port test done");
    load(sfc_pkg::OP_LOAD_ACC, 32'h82500000, 4);
    u_host.tx(sfc_pkg::OP_NEGATE);
    rd_acc(32'h82d00000);
    u_host.tx(sfc_pkg::OP_MAGNITUDE);
    rd_acc(32'h82500000);
    load(sfc_pkg::OP_LOAD_OPD, 32'h81000000, 4);
    ask(sfc_pkg::OP_SUM, 8'h00);
    rd_acc(32'h83080000);
    ask(sfc_pkg::OP_DIFF, 8'h00);
    ask(sfc_pkg::OP_PRODUCT, 8'h00);
    rd_acc(32'h84500000);
    ask(sfc_pkg::OP_QUOT, 8'h00);
    wb(1'b0, 4'h4, 32'h0);
    chk(w, 32'h82500000);
    for (int i = 0; i < 4; i++) begin
      u_host.tx(sfc_pkg::OP_DIGIT);
      ask(da[i], de[i]);
    end
    load(sfc_pkg::OP_LOAD_OPD, 32'h0, 4);
    ask(sfc_pkg::OP_QUOT, 8'h08);
    u_host.tx(sfc_pkg::OP_LOAD_ACC);
    u_host.link_reset();
    rd_acc(32'h82500000);
    $display("arith test done");
    strap_up <= 1'b0;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    ask(sfc_pkg::OP_SUM, 8'h00);
    $display("strap test done");
    close_out();
  end
endmodule : testbench
